// *** hdl/pcs_pkg.sv ***
// Contract
// [R1] two-bit function per low pin: io, rd, wr, rdwr
// [R2] io function acts as quasi-bidirectional port pin
// [R3] read strobe during read pulse in range
// [R4] write strobe during write pulse in range
// [R5] rdwr strobe during either pulse in range
// [R6] sixteen-bit base address per pin, two bytes
// [R7] compare length: 16, a15-a1, a15-a2, a15-a8
// [R8] control bytes hold pin3/2 and pin1/0 fields
// [R9] polarity bits 7:4 set pins 3:0 polarity
// [R10] pins 2,3 in io feed extra interrupts
// [R11] options bits 4:1 enable upper pin high drive
// [R12] options bit 0 adds port 0 pull-ups
// [R13] data latch resets ones, config resets zero
// [R14] extra interrupt control bit layout
// [R15] trigger bit: 1 falling edge, 0 low level
// [R16] edge flag set by hardware, cleared on service
// [R17] priority bit high level, enable gates request
// [R18] io function drives pins from data latch
// [R19] compare uses external access address, pulse-long strobe
package pcs_pkg;
  localparam logic [7:0] ADDR_OPTIONS  = 8'h86;
  localparam logic [7:0] ADDR_P0_LOW   = 8'h84;
  localparam logic [7:0] ADDR_P0_HIGH  = 8'h85;
  localparam logic [7:0] ADDR_P1_LOW   = 8'h94;
  localparam logic [7:0] ADDR_P1_HIGH  = 8'h95;
  localparam logic [7:0] ADDR_P2_LOW   = 8'hac;
  localparam logic [7:0] ADDR_P2_HIGH  = 8'had;
  localparam logic [7:0] ADDR_POLARITY = 8'hae;
  localparam logic [7:0] ADDR_P3_LOW   = 8'hb4;
  localparam logic [7:0] ADDR_P3_HIGH  = 8'hb5;
  localparam logic [7:0] ADDR_EXTRA_IRQ_CONTROL    = 8'hc0;
  localparam logic [7:0] ADDR_CFG_LOW  = 8'hc2;
  localparam logic [7:0] ADDR_CFG_HIGH = 8'hc3;
  localparam logic [7:0] ADDR_DATA     = 8'hd8;
  localparam logic [7:0] RST_DATA      = 8'hff;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] POL_MASK      = 8'hf0;
  localparam logic [7:0] OPT_MASK      = 8'h1f;
  localparam int         OPT_PULLUP    = 0;
  localparam int         OPT_HD_LSB    = 1;
  localparam int         XI_PRI        = 3;
  localparam int         XI_EN         = 2;
  localparam int         XI_FLAG       = 1;
  localparam int         XI_TRIG       = 0;
  localparam logic [1:0] FN_IO   = 2'h0;
  localparam logic [1:0] FN_RD   = 2'h1;
  localparam logic [1:0] FN_WR   = 2'h2;
  localparam logic [1:0] FN_RDWR = 2'h3;
  localparam logic [1:0] CMP_A0  = 2'h0;
  localparam logic [1:0] CMP_A1  = 2'h1;
  localparam logic [1:0] CMP_A2  = 2'h2;
  localparam logic [1:0] CMP_A8  = 2'h3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcs_sfr_t;

  typedef struct packed {
    logic        rd_n;
    logic        wr_n;
    logic [15:0] addr;
  } pcs_xmem_t;

  typedef struct packed {
    logic [7:0]   data;
    logic [7:0]   cfg_lo;
    logic [7:0]   cfg_hi;
    logic [7:0]   pol;
    logic [7:0]   opt;
    logic [7:0]   extra_irq_control;
    logic [3:0][15:0] base;
    logic [7:0]   rdata;
    logic [7:0]   pin_o;
    logic [7:0]   pin_oe;
    logic [7:0]   hd;
    logic         p0_pullup;
    logic         irq2_req;
    logic         irq3_req;
    logic         irq2_hi;
    logic         irq3_hi;
    logic [1:0]   irq_prev;
    logic [7:0]   pin_s1;
    logic [7:0]   pin_s2;
    logic [2:0]   xm_s1;
    logic [2:0]   xm_s2;
    logic [15:0]  xa_s1;
    logic [15:0]  xa_s2;
  } pcs_state_t;
endpackage : pcs_pkg

// *** hdl/pcs_port4.sv ***
module pcs_port4 (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire pcs_pkg::pcs_sfr_t  sfr,
  output logic [7:0]            sfr_rdata,
  input  wire pcs_pkg::pcs_xmem_t xmem,
  input  wire logic             irq2_ack,
  input  wire logic             irq3_ack,
  input  wire logic [7:0]       pin_i,
  output logic [7:0]            pin_o,
  output logic [7:0]            pin_oe,
  output logic [7:0]            high_drive,
  output logic                  port0_pullup_enable,
  output logic                  extra_external_irq_a,
  output logic                  extra_external_irq_b,
  output logic                  extint2_priority,
  output logic                  extint3_priority
);
  pcs_pkg::pcs_state_t cur_ff, nxt_ff;

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b,
                                    input logic [1:0] len);
    logic [15:0] m;
    m = 16'hffff;
    case (len)
      pcs_pkg::CMP_A0: m = 16'hffff;
      pcs_pkg::CMP_A1: m = 16'hfffe;
      pcs_pkg::CMP_A2: m = 16'hfffc;
      pcs_pkg::CMP_A8: m = 16'hff00;
      default:         m = 16'hffff;
    endcase
    return ((a ^ b) & m) == 16'h0000; // see [R7]
  endfunction : addr_hit

  always_comb begin
    logic [1:0] fn;
    logic [1:0] len;
    logic       hit;
    logic       act;
    logic       rd_p;
    logic       wr_p;
    logic [1:0] lvl;
    logic [7:0] xi;
    logic [15:0] cfg_all;
    fn   = 2'h0;
    len  = 2'h0;
    hit  = 1'b0;
    act  = 1'b0;
    rd_p = 1'b0;
    wr_p = 1'b0;
    lvl  = 2'h3;
    xi   = 8'h00;
    // both control bytes as one word so every pin indexes in range
    cfg_all = {cur_ff.cfg_hi, cur_ff.cfg_lo};
    nxt_ff = cur_ff;
    // all pins and the access pulses are asynchronous to mclk
    nxt_ff.pin_s1 = pin_i;
    nxt_ff.pin_s2 = cur_ff.pin_s1;
    nxt_ff.xm_s1  = {xmem.rd_n, xmem.wr_n, 1'b0};
    nxt_ff.xm_s2  = cur_ff.xm_s1;
    nxt_ff.xa_s1  = xmem.addr;
    nxt_ff.xa_s2  = cur_ff.xa_s1;
    rd_p = ~cur_ff.xm_s2[2]; // see [R19]
    wr_p = ~cur_ff.xm_s2[1];
    xi   = cur_ff.extra_irq_control;
    if (sfr.wr) begin
      case (sfr.addr)
        pcs_pkg::ADDR_DATA:     nxt_ff.data   = sfr.wdata; // see [R18]
        pcs_pkg::ADDR_CFG_LOW:  nxt_ff.cfg_lo = sfr.wdata; // see [R8]
        pcs_pkg::ADDR_CFG_HIGH: nxt_ff.cfg_hi = sfr.wdata; // see [R8]
        pcs_pkg::ADDR_POLARITY: nxt_ff.pol    = sfr.wdata & pcs_pkg::POL_MASK; // see [R9]
        pcs_pkg::ADDR_OPTIONS:  nxt_ff.opt    = sfr.wdata & pcs_pkg::OPT_MASK;
        pcs_pkg::ADDR_EXTRA_IRQ_CONTROL:    xi            = sfr.wdata; // see [R14]
        pcs_pkg::ADDR_P0_LOW:   nxt_ff.base[0][7:0]  = sfr.wdata; // see [R6]
        pcs_pkg::ADDR_P0_HIGH:  nxt_ff.base[0][15:8] = sfr.wdata;
        pcs_pkg::ADDR_P1_LOW:   nxt_ff.base[1][7:0]  = sfr.wdata;
        pcs_pkg::ADDR_P1_HIGH:  nxt_ff.base[1][15:8] = sfr.wdata;
        pcs_pkg::ADDR_P2_LOW:   nxt_ff.base[2][7:0]  = sfr.wdata;
        pcs_pkg::ADDR_P2_HIGH:  nxt_ff.base[2][15:8] = sfr.wdata;
        pcs_pkg::ADDR_P3_LOW:   nxt_ff.base[3][7:0]  = sfr.wdata;
        pcs_pkg::ADDR_P3_HIGH:  nxt_ff.base[3][15:8] = sfr.wdata;
        default: ;
      endcase
    end
    // quasi port: write 1 floats high weakly, drive only the zeros
    nxt_ff.pin_o  = cur_ff.data; // see [R2]
    nxt_ff.pin_oe = ~cur_ff.data;
    for (int i = 0; i < 4; i++) begin
      fn  = cfg_all[4*i+2 +: 2]; // see [R1]
      len = cfg_all[4*i +: 2];
      hit = addr_hit(cur_ff.xa_s2, cur_ff.base[i], len); // see [R19]
      case (fn)
        pcs_pkg::FN_RD:   act = rd_p & hit;          // see [R3]
        pcs_pkg::FN_WR:   act = wr_p & hit;          // see [R4]
        pcs_pkg::FN_RDWR: act = (rd_p | wr_p) & hit; // see [R5]
        default:          act = 1'b0;
      endcase
      if (fn != pcs_pkg::FN_IO) begin
        nxt_ff.pin_o[i]  = ~(act ^ cur_ff.pol[4+i]); // see [R9]
        nxt_ff.pin_oe[i] = 1'b1;
      end
    end
    nxt_ff.hd        = {cur_ff.opt[pcs_pkg::OPT_HD_LSB +: 4], 4'h0}; // see [R11]
    nxt_ff.p0_pullup = cur_ff.opt[pcs_pkg::OPT_PULLUP]; // see [R12]
    // extra interrupt inputs only from pins left in io function
    lvl[0] = (cur_ff.cfg_hi[3:2] == pcs_pkg::FN_IO) ? cur_ff.pin_s2[2] : 1'b1; // see [R10]
    lvl[1] = (cur_ff.cfg_hi[7:6] == pcs_pkg::FN_IO) ? cur_ff.pin_s2[3] : 1'b1;
    nxt_ff.irq_prev = lvl;
    for (int k = 0; k < 2; k++) begin
      if (xi[4*k+pcs_pkg::XI_TRIG]) begin
        if (k == 0 ? irq2_ack : irq3_ack) xi[4*k+pcs_pkg::XI_FLAG] = 1'b0; // see [R16]
        // set after clear so a fresh edge wins
        if (cur_ff.irq_prev[k] & ~lvl[k]) xi[4*k+pcs_pkg::XI_FLAG] = 1'b1; // see [R15]
      end else begin
        xi[4*k+pcs_pkg::XI_FLAG] = ~lvl[k]; // see [R15]
      end
    end
    nxt_ff.extra_irq_control    = xi;
    nxt_ff.irq2_req = xi[pcs_pkg::XI_EN] & xi[pcs_pkg::XI_FLAG]; // see [R17]
    nxt_ff.irq3_req = xi[4+pcs_pkg::XI_EN] & xi[4+pcs_pkg::XI_FLAG];
    nxt_ff.irq2_hi  = xi[pcs_pkg::XI_PRI]; // see [R17]
    nxt_ff.irq3_hi  = xi[4+pcs_pkg::XI_PRI];
    case (sfr.addr)
      pcs_pkg::ADDR_DATA:     nxt_ff.rdata = {cur_ff.pin_s2[7:4], cur_ff.data[3:0] & cur_ff.pin_s2[3:0]};
      pcs_pkg::ADDR_CFG_LOW:  nxt_ff.rdata = cur_ff.cfg_lo;
      pcs_pkg::ADDR_CFG_HIGH: nxt_ff.rdata = cur_ff.cfg_hi;
      pcs_pkg::ADDR_POLARITY: nxt_ff.rdata = cur_ff.pol;
      pcs_pkg::ADDR_OPTIONS:  nxt_ff.rdata = cur_ff.opt;
      pcs_pkg::ADDR_EXTRA_IRQ_CONTROL:    nxt_ff.rdata = cur_ff.extra_irq_control;
      pcs_pkg::ADDR_P0_LOW:   nxt_ff.rdata = cur_ff.base[0][7:0];
      pcs_pkg::ADDR_P0_HIGH:  nxt_ff.rdata = cur_ff.base[0][15:8];
      pcs_pkg::ADDR_P1_LOW:   nxt_ff.rdata = cur_ff.base[1][7:0];
      pcs_pkg::ADDR_P1_HIGH:  nxt_ff.rdata = cur_ff.base[1][15:8];
      pcs_pkg::ADDR_P2_LOW:   nxt_ff.rdata = cur_ff.base[2][7:0];
      pcs_pkg::ADDR_P2_HIGH:  nxt_ff.rdata = cur_ff.base[2][15:8];
      pcs_pkg::ADDR_P3_LOW:   nxt_ff.rdata = cur_ff.base[3][7:0];
      pcs_pkg::ADDR_P3_HIGH:  nxt_ff.rdata = cur_ff.base[3][15:8];
      default:                nxt_ff.rdata = pcs_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cur_ff          <= '0; // see [R13]
      cur_ff.data     <= pcs_pkg::RST_DATA; // see [R13]
      cur_ff.pin_o    <= pcs_pkg::RST_DATA;
      cur_ff.pin_s1   <= pcs_pkg::RST_DATA;
      cur_ff.pin_s2   <= pcs_pkg::RST_DATA;
      cur_ff.irq_prev <= 2'h3;
      cur_ff.xm_s1    <= 3'h6;
      cur_ff.xm_s2    <= 3'h6;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign sfr_rdata            = cur_ff.rdata;
  assign pin_o                = cur_ff.pin_o;
  assign pin_oe               = cur_ff.pin_oe;
  assign high_drive           = cur_ff.hd;
  assign port0_pullup_enable  = cur_ff.p0_pullup;
  assign extra_external_irq_a = cur_ff.irq2_req;
  assign extra_external_irq_b = cur_ff.irq3_req;
  assign extint2_priority     = cur_ff.irq2_hi;
  assign extint3_priority     = cur_ff.irq3_hi;
endmodule : pcs_port4

// *** dv/pcs_port4_props.sv ***
module pcs_port4_props (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire pcs_pkg::pcs_sfr_t sfr,
  input wire logic [7:0]        sfr_rdata,
  input wire logic [7:0]        pin_o,
  input wire logic [7:0]        pin_oe,
  input wire logic [7:0]        high_drive,
  input wire logic              port0_pullup_enable,
  input wire logic              extint2_priority,
  input wire logic              extint3_priority
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic opt_w;
  logic xi_w;
  assign opt_w = sfr.wr && sfr.addr == pcs_pkg::ADDR_OPTIONS;
  assign xi_w  = sfr.wr && sfr.addr == pcs_pkg::ADDR_EXTRA_IRQ_CONTROL;
  a_reset_ones: assert property ($rose(resetn) |-> pin_o == 8'hff && pin_oe == 8'h00)
    else $error("pins not released after reset");
  a_hd_follow: assert property (opt_w |=> ##1
    high_drive == {$past(sfr.wdata[4:1], 2), 4'h0}) else $error("high drive mismatch");
  a_pullup_follow: assert property (opt_w |=> ##1
    port0_pullup_enable == $past(sfr.wdata[0], 2)) else $error("pull-up mismatch");
  // priority bits leave the same register stage as the control byte
  a_prio2_follow: assert property (xi_w |=>
    extint2_priority == $past(sfr.wdata[3])) else $error("priority 2 mismatch");
  a_prio3_follow: assert property (xi_w |=>
    extint3_priority == $past(sfr.wdata[7])) else $error("priority 3 mismatch");
  a_pol_reserved: assert property (sfr.addr == pcs_pkg::ADDR_POLARITY |=>
    sfr_rdata[3:0] == 4'h0) else $error("polarity low nibble not zero");
  a_opt_reserved: assert property (sfr.addr == pcs_pkg::ADDR_OPTIONS |=>
    sfr_rdata[7:5] == 3'h0) else $error("options top bits not zero");
  // upper pins are always plain port pins, so they only ever sink
  a_quasi_upper: assert property ((pin_o[7:4] & pin_oe[7:4]) == 4'h0)
    else $error("upper pin driven high");
endmodule : pcs_port4_props

// *** dv/pcs_periph.sv ***
module pcs_periph (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_low,
  output logic [7:0]     pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pins float to the pull-up unless a peripheral sinks them
  always_comb pin_i = (pin_oe & pin_o) | (~pin_oe & ~pull_low);
endmodule : pcs_periph

// *** dv/testbench.sv ***
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, irq2_ack, irq3_ack, pu, irq_a, irq_b, pri2, pri3;
  pcs_pkg::pcs_sfr_t  sfr;
  pcs_pkg::pcs_xmem_t xmem;
  logic [7:0] pin_i, pin_o, pin_oe, high_drive, sfr_rdata, pull_low;
  int n_mismatch = 0;
  int compares = 0;
  localparam logic [7:0] RA [12] = '{pcs_pkg::ADDR_P0_LOW, pcs_pkg::ADDR_P0_HIGH,
    pcs_pkg::ADDR_P1_LOW, pcs_pkg::ADDR_P1_HIGH, pcs_pkg::ADDR_P2_LOW, pcs_pkg::ADDR_P2_HIGH,
    pcs_pkg::ADDR_P3_LOW, pcs_pkg::ADDR_P3_HIGH, pcs_pkg::ADDR_CFG_LOW,
    pcs_pkg::ADDR_CFG_HIGH, pcs_pkg::ADDR_POLARITY, pcs_pkg::ADDR_OPTIONS};
  pcs_port4 dut_u (.mclk, .resetn, .sfr, .sfr_rdata, .xmem, .irq2_ack, .irq3_ack,
    .pin_i, .pin_o, .pin_oe, .high_drive, .port0_pullup_enable(pu),
    .extra_external_irq_a(irq_a), .extra_external_irq_b(irq_b),
    .extint2_priority(pri2), .extint3_priority(pri3));
  pcs_periph peer_u (.pin_o, .pin_oe, .pull_low, .pin_i);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk) sfr.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk) #1 `CHK("rdata", e, sfr_rdata)
  endtask : rd
  // address is set a cycle ahead so the synced pulse never sees a stale address
  task automatic xs(input logic r, input logic [15:0] ad, input logic [3:0] e);
    @(posedge mclk) xmem <= '{rd_n: 1'b1, wr_n: 1'b1, addr: ad};
    @(posedge mclk) xmem <= '{rd_n: !r, wr_n: r, addr: ad};
    repeat (4) @(posedge mclk);
    #1 `CHK("strobe", e, pin_o[3:0])
    @(posedge mclk) xmem <= '{rd_n: 1'b1, wr_n: 1'b1, addr: ad};
    repeat (4) @(posedge mclk);
    #1 `CHK("idle", 4'he, pin_o[3:0])
  endtask : xs
  task automatic t_regs;
    foreach (RA[i]) rd(RA[i], 8'h00);
    rd(pcs_pkg::ADDR_DATA, 8'hff);
    foreach (RA[i]) wr(RA[i], 8'hff);
    foreach (RA[i]) rd(RA[i], RA[i] == pcs_pkg::ADDR_POLARITY ? pcs_pkg::POL_MASK :
      RA[i] == pcs_pkg::ADDR_OPTIONS ? pcs_pkg::OPT_MASK : 8'hff);
    wr(8'h87, 8'hff);
    rd(8'h87, 8'h00);
    `CHK("high_drive", 8'hf0, high_drive)
    `CHK("pullup", 1'b1, pu)
  endtask : t_regs
  task automatic t_strobe;
    wr(pcs_pkg::ADDR_CFG_LOW, 8'h7b);
    wr(pcs_pkg::ADDR_CFG_HIGH, 8'h4e);
    wr(pcs_pkg::ADDR_POLARITY, 8'h10);
    wr(pcs_pkg::ADDR_P0_HIGH, 8'h12);
    wr(pcs_pkg::ADDR_P0_LOW, 8'hff);
    wr(pcs_pkg::ADDR_P1_LOW, 8'h35);
    wr(pcs_pkg::ADDR_P2_LOW, 8'h37);
    wr(pcs_pkg::ADDR_P3_LOW, 8'h34);
    foreach (RA[i]) if (i % 2 == 1 && i < 8) wr(RA[i], 8'h12);
    xs(1'b1, 16'h1234, 4'h0);
    xs(1'b0, 16'h1236, 4'hb);
    xs(1'b1, 16'h1238, 4'hc);
    xs(1'b0, 16'h13ff, 4'he);
    // pin3 to a15-a1 compare: 1235 only hits with bit 0 masked
    wr(pcs_pkg::ADDR_CFG_HIGH, 8'h5e);
    xs(1'b1, 16'h1235, 4'h0);
    `CHK("strobe_oe", 4'hf, pin_oe[3:0])
  endtask : t_strobe
  task automatic t_irq;
    wr(pcs_pkg::ADDR_CFG_LOW, 8'h00);
    wr(pcs_pkg::ADDR_CFG_HIGH, 8'h00);
    wr(pcs_pkg::ADDR_DATA, 8'h5a);
    repeat (3) @(posedge mclk);
    #1 `CHK("pin_oe", 8'ha5, pin_oe)
    rd(pcs_pkg::ADDR_DATA, 8'h5a);
    wr(pcs_pkg::ADDR_DATA, 8'hff);
    wr(pcs_pkg::ADDR_EXTRA_IRQ_CONTROL, 8'h0d);
    @(posedge mclk) pull_low <= 8'h04;
    repeat (5) @(posedge mclk);
    #1 `CHK("irq_a", 1'b1, irq_a)
    `CHK("pri2", 1'b1, pri2)
    @(posedge mclk) irq2_ack <= 1'b1;
    @(posedge mclk) irq2_ack <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK("irq_a_ack", 1'b0, irq_a)
    wr(pcs_pkg::ADDR_EXTRA_IRQ_CONTROL, 8'h40);
    @(posedge mclk) pull_low <= 8'h0c;
    repeat (5) @(posedge mclk);
    #1 `CHK("irq_b", 1'b1, irq_b)
    `CHK("irq_a_off", 1'b0, irq_a)
    rd(pcs_pkg::ADDR_EXTRA_IRQ_CONTROL, 8'h62);
    @(posedge mclk) pull_low <= 8'h00;
    repeat (5) @(posedge mclk);
    #1 `CHK("irq_b_rel", 1'b0, irq_b)
    // interrupt 3 in edge mode, high priority, cleared by its own service
    wr(pcs_pkg::ADDR_EXTRA_IRQ_CONTROL, 8'hd0);
    @(posedge mclk) pull_low <= 8'h08;
    repeat (5) @(posedge mclk);
    #1 `CHK("irq_b_edge", 1'b1, irq_b)
    `CHK("pri3", 1'b1, pri3)
    @(posedge mclk) irq3_ack <= 1'b1;
    @(posedge mclk) irq3_ack <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK("irq_b_ack", 1'b0, irq_b)
  endtask : t_irq
  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    resetn = 1'b0;
    irq2_ack = 1'b0;
    irq3_ack = 1'b0;
    pull_low = 8'h00;
    sfr = '0;
    xmem = '{rd_n: 1'b1, wr_n: 1'b1, addr: 16'h0000};
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_strobe();
    t_irq();
    complete_run();
  end
  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end
endmodule : testbench
bind pcs_port4 pcs_port4_props chk_u (.mclk, .resetn, .sfr, .sfr_rdata, .pin_o, .pin_oe,
  .high_drive, .port0_pullup_enable, .extint2_priority, .extint3_priority);
